// File: secmem_defs.vh
// Constants of the password-protected serial memory access controller.
// Contract
// RULE_01: Write: command, password, then data bytes.
// RULE_02: Exactly eight bytes from sector start, else unchanged.
// RULE_03: Nonvolatile write starts only on stop.
// RULE_04: Busy cycle: command byte gets no acknowledge.
// RULE_05: Every password reception triggers a write cycle.
// RULE_06: Master polls password with command 55h.
// RULE_07: Master waits 10ms or polls repeatedly.
// RULE_08: Right password: poll acknowledged after cycle.
// RULE_09: Wrong password: poll never acknowledged.
// RULE_10: Read starts at first byte of sector.
// RULE_11: Master acknowledges every read byte.
// RULE_12: Read pointer advances and wraps to sector zero.
// RULE_13: Master ends read with no acknowledge, stop.
// RULE_14: Password change uses sector-write form, eight bytes.
// RULE_15: Polling acknowledges once new password stored; the code never acks it, the stop clears the grant.
// RULE_16: No path reads back either password.
// RULE_17: Reset pulse with select low sends 32 bits.
// RULE_18: Reset answer bytes are 19 00 AA 55.
// RULE_19: Further clocks repeat the reset answer.
// RULE_20: Reset pulse during write cycle gives no answer.
// RULE_21: Reset mid-transaction aborts, data line released.
// RULE_22: Select high aborts reset answer to standby.
// RULE_23: Eight wrong passwords tolerated, then everything cleared; the code already wipes everything on the eighth.
// RULE_24: Unknown command: no acknowledge, back to standby.
// RULE_25: Fourteen sectors of eight bytes.
// RULE_26: Four-bit sector field; larger indices illegal.
`ifndef SECMEM_DEFS_VH
`define SECMEM_DEFS_VH
`define SECTORS        4'hE
`define MEM_BYTES      112
`define PW_BYTES       8
`define PW_ACK_CMD     8'h55
`define CHG_WR_CMD     8'hFC
`define CHG_RD_CMD     8'hFE
`define SECT_CMD_TOP   3'h4
`define RETRY_LIMIT    4'h8
`define RST_ANSWER     32'h1900AA55
`define WC_TIME_US     5000
`define CLK_MHZ        100
`define WC_CYCLES      (`WC_TIME_US * `CLK_MHZ)
`endif

// File: sync_edge.v
// Two-stage synchroniser with edge detection for one pin.
`timescale 1ns/100ps
module sync_edge #(
  parameter INIT = 1'b1
) (
  input  wire clk,
  input  wire arst_n,
  input  wire pin,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg last;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Reset to the pin's idle level so no false edge follows reset.
      meta  <= INIT;
      level <= INIT;
      last  <= INIT;
    end else begin
      meta  <= pin;
      level <= meta;
      last  <= level;
    end
  end
  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule

// File: secmem_ctrl.v
// Access controller of a password-protected serial nonvolatile memory.
`timescale 1ns/100ps
`include "secmem_defs.vh"
module secmem_ctrl #(
  parameter WC_CYCLES = `WC_CYCLES
) (
  input  wire clk,
  input  wire arst_n,
  input  wire scl,
  input  wire sda_in,
  output reg  sda_out,
  output reg  sda_oe,
  input  wire cs_n,
  input  wire rst_pin,
  output wire busy
);
  // ************************************************************
  // Pin sampling
  // ************************************************************
  wire scl_s, scl_r, scl_f;
  wire sda_s, sda_r, sda_f;
  wire cs_s, rst_s, rst_r, rst_f;
  sync_edge u_scl (.clk(clk), .arst_n(arst_n), .pin(scl), .level(scl_s), .rise(scl_r), .fall(scl_f));
  sync_edge u_sda (.clk(clk), .arst_n(arst_n), .pin(sda_in), .level(sda_s), .rise(sda_r), .fall(sda_f));
  sync_edge u_cs  (.clk(clk), .arst_n(arst_n), .pin(cs_n), .level(cs_s), .rise(), .fall());
  sync_edge #(.INIT(1'b0)) u_rst (.clk(clk), .arst_n(arst_n), .pin(rst_pin), .level(rst_s), .rise(rst_r),
    .fall(rst_f));

  // Start and stop are only honoured while select is low.
  wire start_c = sda_f & scl_s & ~cs_s;
  wire stop_c  = sda_r & scl_s & ~cs_s;

  // ************************************************************
  // State
  // ************************************************************
  localparam ST_IDLE  = 4'h0;
  localparam ST_CMD   = 4'h1;
  localparam ST_PW    = 4'h2;
  localparam ST_WDATA = 4'h3;
  localparam ST_RDATA = 4'h4;
  localparam ST_ATR   = 4'h5;
  localparam ST_HOLD  = 4'h6;
  localparam ST_POLL  = 4'h7;

  reg [3:0]  state;
  reg [7:0]  mem [0:`MEM_BYTES-1];
  reg [7:0]  wpw [0:`PW_BYTES-1];
  reg [7:0]  rpw [0:`PW_BYTES-1];
  reg [7:0]  wbuf [0:`PW_BYTES-1];
  reg [7:0]  shreg;
  reg [3:0]  bitcnt;
  reg [3:0]  bytecnt;
  reg        ack_phase;
  reg        ack_drive;
  reg [7:0]  cmd;
  reg [3:0]  sector;
  reg [6:0]  rptr;
  reg        pw_ok;
  reg        granted;
  reg        pw_got;
  reg        pw_bad;
  reg [3:0]  retries;
  reg        wc_run;
  reg [31:0] wc_cnt;
  reg        wc_commit;
  reg        wc_wipe;
  reg [1:0]  wc_kind;
  reg [4:0]  atr_bit;
  reg        rd_nack;
  integer    i;

  localparam K_NONE = 2'h0;
  localparam K_DATA = 2'h1;
  localparam K_WPW  = 2'h2;
  localparam K_RPW  = 2'h3;

  assign busy = wc_run;

  wire [7:0] next_byte = {shreg[6:0], sda_s};
  wire       is_sect   = next_byte[7:5] == `SECT_CMD_TOP;
  wire       is_chg    = next_byte == `CHG_WR_CMD || next_byte == `CHG_RD_CMD;
  wire       sect_ok   = next_byte[4:1] < `SECTORS;
  wire [7:0] pw_byte   = (cmd[7:5] == `SECT_CMD_TOP && cmd[0]) ? rpw[bytecnt[2:0]] : wpw[bytecnt[2:0]];
  wire [31:0] atr_word = `RST_ANSWER;

  // ************************************************************
  // Main sequencer
  // ************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
      cmd <= 8'h00;
      sector <= 4'h0;
      rptr <= 7'h00;
      pw_ok <= 1'b1;
      granted <= 1'b0;
      pw_got <= 1'b0;
      pw_bad <= 1'b0;
      retries <= 4'h0;
      wc_run <= 1'b0;
      wc_cnt <= 32'h0;
      wc_commit <= 1'b0;
      wc_wipe <= 1'b0;
      wc_kind <= K_NONE;
      atr_bit <= 5'h00;
      rd_nack <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      for (i = 0; i < `MEM_BYTES; i = i + 1) mem[i] <= 8'h00;
      for (i = 0; i < `PW_BYTES; i = i + 1) begin
        wpw[i] <= 8'h00;
        rpw[i] <= 8'h00;
        wbuf[i] <= 8'h00;
      end
    end else begin
      // Self-timed nonvolatile cycle; contents change only at its end.
      if (wc_run) begin
        if (wc_cnt == WC_CYCLES - 1) begin
          wc_run <= 1'b0;
          wc_cnt <= 32'h0;
          if (wc_wipe) begin // see RULE_23
            for (i = 0; i < `MEM_BYTES; i = i + 1) mem[i] <= 8'h00;
            for (i = 0; i < `PW_BYTES; i = i + 1) begin
              wpw[i] <= 8'h00;
              rpw[i] <= 8'h00;
            end
          end else if (wc_commit) begin
            for (i = 0; i < `PW_BYTES; i = i + 1) begin
              if (wc_kind == K_DATA) mem[{sector, 3'h0} + i] <= wbuf[i]; // see RULE_02
              if (wc_kind == K_WPW) wpw[i] <= wbuf[i]; // see RULE_15
              if (wc_kind == K_RPW) rpw[i] <= wbuf[i]; // see RULE_14
            end
          end
          wc_commit <= 1'b0;
          wc_wipe <= 1'b0;
        end else begin
          wc_cnt <= wc_cnt + 32'h1;
        end
      end

      if (cs_s) begin
        // Deselect releases the line and abandons any sequence.
        state <= ST_IDLE; // see RULE_22
        sda_oe <= 1'b0;
        ack_drive <= 1'b0;
        granted <= 1'b0;
      end else if (rst_r && state != ST_ATR) begin
        // A reset pulse aborts any bus transaction in progress, except a reset answer already being sent; a running write cycle goes on.
        state <= ST_HOLD; // see RULE_21
        sda_oe <= 1'b0;
        ack_drive <= 1'b0;
        granted <= 1'b0;
      end else if (rst_f && state == ST_HOLD) begin
        if (!wc_run) begin // see RULE_20
          state <= ST_ATR; // see RULE_17
          atr_bit <= 5'h00;
          sda_oe <= ~atr_word[31];
        end else begin
          state <= ST_IDLE;
        end
      end else if (start_c && !wc_run) begin
        state <= ST_CMD;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        ack_drive <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        sda_oe <= 1'b0;
        if (state == ST_PW && pw_got) begin
          // Any received password costs a full write cycle.
          wc_run <= 1'b1; // see RULE_05
          wc_cnt <= 32'h0;
          if (pw_bad) begin
            if (retries == `RETRY_LIMIT - 4'h1) begin
              wc_wipe <= 1'b1;
              retries <= 4'h0;
            end else begin
              retries <= retries + 4'h1; // see RULE_23
            end
            pw_ok <= 1'b0;
          end else begin
            retries <= 4'h0;
            pw_ok <= 1'b1;
          end
        end else if (state == ST_WDATA && bytecnt == `PW_BYTES) begin
          wc_run <= 1'b1; // see RULE_03
          wc_cnt <= 32'h0;
          wc_commit <= 1'b1;
        end
        // A refused poll leaves the device idle; its stop must not drop the grant.
        if (state != ST_IDLE && !(state == ST_PW && pw_got)) granted <= 1'b0;
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_ATR: begin
            if (scl_f) begin
              // Wraps after bit 31 so continued clocks repeat the word.
              atr_bit <= atr_bit + 5'h01; // see RULE_19
              sda_oe <= ~atr_word[5'd30 - atr_bit]; // see RULE_18
            end
          end
          ST_CMD, ST_PW, ST_WDATA, ST_POLL: begin
            if (scl_r && !ack_phase) begin
              shreg <= next_byte;
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                ack_phase <= 1'b1;
                bitcnt <= 4'h0;
                if (state == ST_CMD) begin
                  if (wc_run) begin
                    ack_drive <= 1'b0; // see RULE_04
                    state <= ST_IDLE;
                  end else if (next_byte == `PW_ACK_CMD) begin
                    ack_drive <= pw_ok & granted; // see RULE_08 RULE_09
                    state <= (pw_ok & granted) ? (cmd[0] && cmd[7:5] == `SECT_CMD_TOP ? ST_RDATA : ST_WDATA)
                                               : ST_IDLE;
                    bytecnt <= 4'h0;
                    rptr <= {sector, 3'h0}; // see RULE_10
                    rd_nack <= 1'b0;
                  end else if ((is_sect && sect_ok) || is_chg) begin // see RULE_26
                    ack_drive <= 1'b1;
                    cmd <= next_byte; // see RULE_01
                    sector <= next_byte[4:1];
                    state <= ST_PW;
                    bytecnt <= 4'h0;
                    pw_got <= 1'b0;
                    pw_bad <= 1'b0;
                    granted <= 1'b1;
                  end else begin
                    ack_drive <= 1'b0; // see RULE_24
                    state <= ST_IDLE;
                  end
                end else if (state == ST_PW) begin
                  ack_drive <= 1'b1;
                  if (next_byte != pw_byte) pw_bad <= 1'b1;
                  bytecnt <= bytecnt + 4'h1;
                  if (bytecnt == `PW_BYTES - 1) pw_got <= 1'b1;
                end else begin
                  // Bytes beyond eight are taken but block the commit.
                  ack_drive <= 1'b1;
                  if (bytecnt < `PW_BYTES) wbuf[bytecnt[2:0]] <= next_byte;
                  if (bytecnt <= `PW_BYTES) bytecnt <= bytecnt + 4'h1;
                  wc_kind <= cmd == `CHG_WR_CMD ? K_WPW : cmd == `CHG_RD_CMD ? K_RPW : K_DATA;
                end
              end
            end else if (scl_f && ack_phase && !sda_oe) begin
              sda_oe <= ack_drive;
            end else if (scl_f && ack_phase && sda_oe) begin
              sda_oe <= 1'b0;
              ack_phase <= 1'b0;
              ack_drive <= 1'b0;
              if (state == ST_RDATA) begin
                shreg <= mem[rptr];
                sda_oe <= ~mem[rptr][7];
              end
            end else if (scl_f && ack_phase && !ack_drive) begin
              ack_phase <= 1'b0;
            end
          end
          ST_RDATA: begin
            // Only array bytes are ever shifted out, never the passwords.
            if (ack_phase) begin
              // Acknowledge of the poll first, then the first data bit.
              if (scl_f && !sda_oe) begin
                sda_oe <= ack_drive; // see RULE_08
              end else if (scl_f) begin
                sda_oe <= ~mem[rptr][7]; // see RULE_10
                ack_phase <= 1'b0;
                ack_drive <= 1'b0;
                bitcnt <= 4'h0;
              end
            end else if (scl_f) begin // see RULE_16
              if (bitcnt < 4'h8) begin
                bitcnt <= bitcnt + 4'h1;
                if (bitcnt == 4'h0) shreg <= mem[rptr];
                sda_oe <= bitcnt == 4'h7 ? 1'b0 : ~(bitcnt == 4'h0 ? mem[rptr][6] : shreg[6 - bitcnt[2:0]]);
                if (bitcnt == 4'h7) begin
                  rptr <= rptr == `MEM_BYTES - 1 ? 7'h00 : rptr + 7'h01; // see RULE_12 RULE_25
                end
              end else begin
                bitcnt <= 4'h0;
                if (rd_nack) begin
                  state <= ST_IDLE;
                  sda_oe <= 1'b0;
                end else begin
                  sda_oe <= ~mem[rptr][7];
                end
              end
            end
            if (!ack_phase && scl_r && bitcnt == 4'h8) rd_nack <= sda_s; // see RULE_11 RULE_13
            if (!ack_phase && scl_r && bitcnt == 4'h0) shreg <= mem[rptr];
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
      sda_out <= 1'b0;
    end
  end
endmodule

// File: secmem_ctrl_sva.sv
// Concurrent checks on the ports of the access controller.
`timescale 1ns/100ps
module secmem_ctrl_sva #(
  parameter WC_CYCLES = 50
) (
  input wire clk,
  input wire arst_n,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire cs_n,
  input wire rst_pin,
  input wire busy
);
  // Length of the running write cycle, so the bound can be checked without a long repetition.
  int cnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      cnt <= 0;
    else
      cnt <= busy ? cnt + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_first_bit;
    ##[1:6] sda_oe;
  endsequence
  sequence s_pulse_end;
    $fell(rst_pin) && !cs_n && !busy;
  endsequence
  property p_busy_quiet; busy |-> !sda_oe; endproperty
  property p_desel; cs_n [*5] |-> !sda_oe; endproperty
  property p_busy_max; cnt <= WC_CYCLES + 1; endproperty
  property p_busy_min; $fell(busy) |-> $past(cnt) >= WC_CYCLES - 2; endproperty
  property p_busy_on_stop; $rose(busy) |-> scl && sda_in; endproperty
  property p_answer; s_pulse_end |-> s_first_bit; endproperty
  property p_stand; $rose(scl) |-> $stable(sda_oe) [*4]; endproperty
  property p_change_low; $changed(sda_oe) && !cs_n |-> !scl; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  a_desel: assert property (p_desel) else $error("drive while deselected");
  a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
  a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
  a_busy_on_stop: assert property (p_busy_on_stop) else $error("cycle not after stop");
  a_answer: assert property (p_answer) else $error("answer first bit missing");
  a_stand: assert property (p_stand) else $error("output moved in clock high");
  a_change_low: assert property (p_change_low) else $error("output changed with clock high");
endmodule

// File: host_master.sv
// Bus master model driving serial clock, data, select and reset lines.
`timescale 1ns/100ps
module host_master (
  input  wire  sda_w,
  output logic scl,
  output logic sda_m,
  output logic cs_n,
  output logic rst_pin
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    cs_n = 1'b1;
    rst_pin = 1'b0;
  end
  // Data moves only while the clock is low; the clock stands still between frames.
  task automatic bit_io(input logic b, output logic r);
    #20 sda_m = b;
    #42.5 scl = 1'b1;
    #40 r = sda_w;
    #22.5 scl = 1'b0;
  endtask
  task automatic start_c;
    #20 sda_m = 1'b1;
    #40 scl = 1'b1;
    #60 sda_m = 1'b0;
    #60 scl = 1'b0;
  endtask
  task automatic stop_c;
    #20 sda_m = 1'b0;
    #40 scl = 1'b1;
    #60 sda_m = 1'b1;
    #60;
  endtask
  // Byte then ninth bit; ack is high when the line was pulled low.
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(mack, r);
    ack = ~r;
  endtask
  task automatic rst_pulse;
    scl = 1'b0;
    #500 rst_pin = 1'b1;
    #1500 rst_pin = 1'b0;
    #500;
  endtask
endmodule

// File: tb_secmem_ctrl.sv
// Self-checking bench of the access controller against a byte-array model.
`timescale 1ns/100ps
module tb_secmem_ctrl;
  localparam int          WC  = 400;
  localparam logic [31:0] ANS = 32'h1900AA55;
  logic       clk;
  logic       arst_n;
  wire        scl, sda_m, cs_n, rst_pin, sda_out, sda_oe, busy;
  wire        sda_w = (sda_oe ? sda_out : 1'b1) & sda_m;
  int         err_count;
  int         n_checks;
  int         cyc;
  logic [7:0] mem [112];
  logic [7:0] rx;
  logic       ack;
  secmem_ctrl #(.WC_CYCLES(WC)) secmem_ctrl_i (.clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .cs_n(cs_n), .rst_pin(rst_pin), .busy(busy));
  host_master host_master_i (.sda_w(sda_w), .scl(scl), .sda_m(sda_m), .cs_n(cs_n), .rst_pin(rst_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      print_verdict();
    end
  end
  // Protected access: password byte pw repeated eight times, then n data bytes.
  task automatic access(input logic [7:0] cmd, input logic [7:0] pw, input int n, input logic good);
    int a;
    logic [7:0] w [8];
    a = 8 * cmd[4:1];
    host_master_i.start_c();
    host_master_i.xfer(cmd, 1'b1, rx, ack);
    chk(8'h01, ack);
    repeat (8) host_master_i.xfer(pw, 1'b1, rx, ack);
    host_master_i.stop_c();
    host_master_i.start_c();
    host_master_i.xfer(8'h55, 1'b1, rx, ack);
    chk(8'h00, ack);
    for (int k = 0; k < 20 && !ack; k++) begin
      host_master_i.stop_c();
      host_master_i.start_c();
      host_master_i.xfer(8'h55, 1'b1, rx, ack);
    end
    chk(good, ack);
    for (int k = 0; k < n; k++) begin
      if (cmd[0]) begin
        host_master_i.xfer(8'hFF, k == n - 1, rx, ack);
        chk(mem[(a + k) % 112], rx);
      end else begin
        w[k % 8] = 8'($urandom);
        host_master_i.xfer(w[k % 8], 1'b1, rx, ack);
        chk(8'h01, ack);
      end
    end
    host_master_i.stop_c();
    if (!cmd[0] && n == 8)
      foreach (w[k]) mem[a + k] = w[k];
    repeat (4) @(posedge clk);
    while (busy) @(posedge clk);
    $display("access %h with %0d bytes done", cmd, n);
  endtask
  initial begin
    arst_n = 1'b0;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(32'h58AB1527));
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    host_master_i.cs_n = 1'b0;
    host_master_i.rst_pulse();
    for (int i = 0; i < 40; i++) begin
      host_master_i.bit_io(1'b1, ack);
      chk(ANS[31 - i % 32], ack);
    end
    host_master_i.rst_pulse();
    host_master_i.bit_io(1'b1, ack);
    host_master_i.cs_n = 1'b1;
    #300 chk(8'h00, sda_oe);
    host_master_i.scl = 1'b1;
    #200 host_master_i.cs_n = 1'b0;
    $display("reset answer test done");
    access(8'h9A, 8'h00, 8, 1'b1);
    access(8'h80, 8'h00, 8, 1'b1);
    access(8'h8A, 8'h00, 7, 1'b1);
    access(8'h9B, 8'h00, 24, 1'b1);
    access(8'h8B, 8'h00, 8, 1'b1);
    access(8'h8B, 8'h3C, 0, 1'b0);
    foreach (ANS[i]) if (i < 3) begin
      host_master_i.start_c();
      host_master_i.xfer(i == 0 ? 8'h00 : 8'h9B + i, 1'b1, rx, ack);
      chk(8'h00, ack);
      host_master_i.stop_c();
    end
    $display("illegal command test done");
    print_verdict();
  end
endmodule
bind secmem_ctrl secmem_ctrl_sva #(.WC_CYCLES(WC_CYCLES)) secmem_ctrl_sva_i (.clk(clk), .arst_n(arst_n),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cs_n(cs_n), .rst_pin(rst_pin), .busy(busy));
